//--- design/ali_pkg.sv
// Constants for the activity indicator block: bus map, field layout, timing.
// Assumes a 100 MHz core clock and an APB master with 32-bit data.
//
// Summary of operation
// - Both green power LEDs show a soft, dim blinking heartbeat while running.
// - Input-side receive LED pulses on any MIDI-in or USB-in message.
// - Input-side receive LED also pulses on a received parameter edit message.
// - Input-side transmit LED pulses on any message sent on MIDI out or USB.
// - At power-up the three input-side status LEDs light one after another.
// - A jack LED is fully off while no plug is detected, except when the chase pattern steps onto it.
// - A jack LED is dim and steady as soon as a plug is detected.
// - A jack LED flashes bright when that input emits a message.
// - USB receive LED lights briefly on each message arriving over USB.
// - USB transmit LED lights briefly on each message sent over USB.
// - MIDI input LED lights briefly on each message arriving on MIDI in.
// - MIDI output LED lights briefly on each message sent on MIDI out.
// - With phantom power on, the MIDI input LED is held dim and steady.
// - With phantom power on, MIDI input messages still flash that LED bright.
// - Save to flash after ten idle seconds; every edit restarts the timer.
// - A chase pattern runs while the flash write lasts, then normal display.
// - Router merges pedal, MIDI-in, USB-in to both outputs, never USB to USB.
// - Five routing switches, pedals ganged, all on after reset.

package ali_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR   = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;

  // CTRL fields
  localparam int SW_PED_MIDI   = 0;
  localparam int SW_THRU       = 1;
  localparam int SW_USB_MIDI   = 2;
  localparam int SW_PED_USB    = 3;
  localparam int SW_MIDI_USB   = 4;
  localparam int PHANTOM_BIT   = 5;
  localparam int CTRL_W        = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h1F;

  // STATUS fields
  localparam int ST_JACK_LSB    = 0;
  localparam int ST_MODE_LSB    = 8;
  localparam int ST_PENDING_BIT = 10;
  localparam int ST_BUSY_BIT    = 11;

  // ---------------------------------------------------------------------------
  // LED vector layout
  // ---------------------------------------------------------------------------
  localparam int N_JACK      = 8;
  localparam int LED_PWR_IN  = 8;
  localparam int LED_RX      = 9;
  localparam int LED_TX      = 10;
  localparam int LED_PWR_OUT = 11;
  localparam int LED_USB_RX  = 12;
  localparam int LED_USB_TX  = 13;
  localparam int LED_MIDI_IN = 14;
  localparam int LED_MIDI_OUT = 15;
  localparam int N_LED       = 16;
  localparam int N_STR       = 14;
  localparam int STR_JACK0   = 6;

  // ---------------------------------------------------------------------------
  // PWM levels
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PWM_DIM    = 8'h10;
  localparam logic [7:0] PWM_BRIGHT = 8'hFF;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam longint CLK_HZ      = 100000000;
  localparam longint CYC_PER_MS  = CLK_HZ / 1000;
  localparam longint PULSE_MS    = 50;
  localparam longint STEP_MS     = 200;
  localparam longint HEART_MS    = 1000;
  localparam longint IDLE_S      = 10;
  localparam int unsigned PULSE_CYC = 32'(PULSE_MS * CYC_PER_MS);
  localparam int unsigned STEP_CYC  = 32'(STEP_MS * CYC_PER_MS);
  localparam int unsigned HEART_CYC = 32'(HEART_MS * CYC_PER_MS);
  localparam int unsigned IDLE_CYC  = 32'(IDLE_S * CLK_HZ);

  typedef enum logic [1:0] {
    MODE_POWERUP,
    MODE_RUN,
    MODE_SAVE_REQ,
    MODE_CHASE
  } ali_mode_e;

endpackage : ali_pkg

//--- design/ali_stretch.sv
// Retriggerable pulse stretcher for one activity indicator.
// Assumes a single synchronous clock and an active-high synchronous reset.
`timescale 1ns/10ps
`default_nettype none

module ali_stretch #(
  parameter int unsigned P_LEN = 32'd5000000
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_trig,
  output var  logic o_active
);

  logic [31:0] cnt_reg;

  // ---------------------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------------------
  // retrigger reloads count
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      cnt_reg <= 32'h0;
    else if (i_trig)
      cnt_reg <= P_LEN[31:0];
    else if (cnt_reg != 32'h0)
      cnt_reg <= cnt_reg - 32'h1;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_active <= 1'b0;
    else
      o_active <= i_trig || (cnt_reg > 32'h1);
  end

endmodule : ali_stretch

`default_nettype wire

//--- design/ali_top.sv
// Front-panel indicator controller with message router flags and save timer.
// Assumes synchronous event strobes, an APB master, and a flash controller
// that raises i_flash_busy for the length of a write.
`timescale 1ns/10ps
`default_nettype none

module ali_top #(
  parameter int unsigned P_PULSE_CYC = ali_pkg::PULSE_CYC,
  parameter int unsigned P_STEP_CYC  = ali_pkg::STEP_CYC,
  parameter int unsigned P_HEART_CYC = ali_pkg::HEART_CYC,
  parameter int unsigned P_IDLE_CYC  = ali_pkg::IDLE_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_sys_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pready,
  output var  logic        o_pslverr,
  // Message engine strobes
  input  wire logic        i_midi_in_evt,
  input  wire logic        i_usb_in_evt,
  input  wire logic        i_edit_evt,
  input  wire logic [7:0]  i_pedal_evt,
  input  wire logic [7:0]  i_jack_present,
  // Flash save handshake
  input  wire logic        i_flash_busy,
  output var  logic        o_flash_start,
  // Router forwarding strobes and registered switch levels
  output var  logic        o_fwd_midi_out,
  output var  logic        o_fwd_usb_out,
  output var  logic        o_thru_forward_switch,
  output var  logic        o_midi_phantom_power,
  // LEDs
  output var  logic        o_led_pwr_in,
  output var  logic        o_led_pwr_out,
  output var  logic        o_led_rx,
  output var  logic        o_led_tx,
  output var  logic        o_led_usb_rx,
  output var  logic        o_led_usb_tx,
  output var  logic        o_led_midi_in,
  output var  logic        o_led_midi_out,
  output var  logic [7:0]  o_led_jack
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [ali_pkg::CTRL_W-1:0] ctrl_reg;
  logic                       pending_reg;
  logic [31:0]                idle_reg;
  logic [31:0]                step_reg;
  logic [31:0]                heart_reg;
  logic                       heart_on_reg;
  logic [7:0]                 pwm_reg;
  logic [3:0]                 seq_reg;
  ali_pkg::ali_mode_e         mode_reg;
  ali_pkg::ali_mode_e         mode_next;
  logic [ali_pkg::N_LED-1:0]  led_reg;
  logic [ali_pkg::N_LED-1:0]  led_next;
  logic [ali_pkg::N_STR-1:0]  trig;
  logic [ali_pkg::N_STR-1:0]  act;
  logic                       apb_access;
  logic                       apb_write;
  logic                       ctrl_hit;
  logic                       status_hit;
  logic                       edit_any;
  logic                       pedal_any;
  logic                       route_midi;
  logic                       route_usb;
  logic                       idle_done;
  logic                       step_done;

  // Shared PWM compare for all LEDs
  function automatic logic pwm_level(input logic [7:0] duty, input logic [7:0] cnt);
    pwm_level = (cnt < duty) || (duty == ali_pkg::PWM_BRIGHT);
  endfunction : pwm_level

  function automatic logic led_drive(input logic bright, input logic dim, input logic [7:0] cnt);
    if (bright)
      led_drive = pwm_level(ali_pkg::PWM_BRIGHT, cnt);
    else if (dim)
      led_drive = pwm_level(ali_pkg::PWM_DIM, cnt);
    else
      led_drive = 1'b0;
  endfunction : led_drive

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  // One wait state: the answer comes one cycle into the access phase.
  assign apb_access = i_psel && i_penable && !o_pready;
  assign apb_write  = i_psel && i_penable && o_pready && i_pwrite;
  assign ctrl_hit   = (i_paddr == ali_pkg::CTRL_ADDR);
  assign status_hit = (i_paddr == ali_pkg::STATUS_ADDR);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_pready <= 1'b0;
    else
      o_pready <= apb_access;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_pslverr <= 1'b0;
    else
      o_pslverr <= apb_access && !ctrl_hit && !status_hit;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_prdata <= 32'h0;
    else if (apb_access && !i_pwrite && ctrl_hit)
      o_prdata <= {26'h0, ctrl_reg};
    else if (apb_access && !i_pwrite && status_hit)
    begin
      o_prdata <= 32'h0;
      o_prdata[ali_pkg::ST_JACK_LSB +: 8] <= i_jack_present;
      o_prdata[ali_pkg::ST_MODE_LSB +: 2] <= mode_reg;
      o_prdata[ali_pkg::ST_PENDING_BIT]   <= pending_reg;
      o_prdata[ali_pkg::ST_BUSY_BIT]      <= i_flash_busy;
    end
    else if (apb_access)
      o_prdata <= 32'h0;
  end

  // Write lands where the master sees pready
  // switches all on
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      ctrl_reg <= ali_pkg::CTRL_RST;
    else if (apb_write && ctrl_hit)
      ctrl_reg <= i_pwdata[ali_pkg::CTRL_W-1:0];
  end

  // ---------------------------------------------------------------------------
  // Router
  // ---------------------------------------------------------------------------
  assign pedal_any = |i_pedal_evt;

  assign route_midi = (pedal_any && ctrl_reg[ali_pkg::SW_PED_MIDI])
                   || (i_midi_in_evt && ctrl_reg[ali_pkg::SW_THRU])
                   || (i_usb_in_evt && ctrl_reg[ali_pkg::SW_USB_MIDI]);
  assign route_usb  = (pedal_any && ctrl_reg[ali_pkg::SW_PED_USB])
                   || (i_midi_in_evt && ctrl_reg[ali_pkg::SW_MIDI_USB]);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_fwd_midi_out <= 1'b0;
      o_fwd_usb_out  <= 1'b0;
    end
    else
    begin
      o_fwd_midi_out <= route_midi;
      o_fwd_usb_out  <= route_usb;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      o_thru_forward_switch <= 1'b1;
      o_midi_phantom_power  <= 1'b0;
    end
    else
    begin
      o_thru_forward_switch <= ctrl_reg[ali_pkg::SW_THRU];
      o_midi_phantom_power  <= ctrl_reg[ali_pkg::PHANTOM_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Activity stretchers
  // ---------------------------------------------------------------------------
  // receive from either port
  assign trig[0] = i_midi_in_evt || i_usb_in_evt || i_edit_evt;
  assign trig[1] = route_midi || route_usb;
  assign trig[2] = i_usb_in_evt;
  assign trig[3] = route_usb;
  assign trig[4] = i_midi_in_evt;
  assign trig[5] = route_midi;
  assign trig[ali_pkg::N_STR-1:ali_pkg::STR_JACK0] = i_pedal_evt & i_jack_present;

  genvar gi;
  generate
    for (gi = 0; gi < ali_pkg::N_STR; gi++)
    begin : g_str
      ali_stretch #(
        .P_LEN (P_PULSE_CYC)
      ) u_str (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_trig     (trig[gi]),
        .o_active   (act[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // PWM and heartbeat
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      pwm_reg <= 8'h0;
    else
      pwm_reg <= pwm_reg + 8'h1;
  end

  // Half period on, half off
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
    begin
      heart_reg    <= 32'h0;
      heart_on_reg <= 1'b1;
    end
    else if (heart_reg >= (P_HEART_CYC[31:0] >> 1) - 32'h1)
    begin
      heart_reg    <= 32'h0;
      heart_on_reg <= !heart_on_reg;
    end
    else
      heart_reg <= heart_reg + 32'h1;
  end

  // ---------------------------------------------------------------------------
  // Save timer
  // ---------------------------------------------------------------------------
  assign edit_any  = i_edit_evt || (apb_write && ctrl_hit);
  assign idle_done = pending_reg && !edit_any && (idle_reg >= P_IDLE_CYC[31:0] - 32'h1);

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      idle_reg <= 32'h0;
    else if (edit_any || !pending_reg)
      idle_reg <= 32'h0;
    else if (!idle_done)
      idle_reg <= idle_reg + 32'h1;
  end

  // Edit at expiry keeps save pending
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      pending_reg <= 1'b0;
    else if (edit_any)
      pending_reg <= 1'b1;
    else if (idle_done && mode_reg == ali_pkg::MODE_RUN)
      pending_reg <= 1'b0;
  end

  // ---------------------------------------------------------------------------
  // Mode sequencer
  // ---------------------------------------------------------------------------
  assign step_done = (step_reg >= P_STEP_CYC[31:0] - 32'h1);

  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      ali_pkg::MODE_POWERUP:
        if (step_done && seq_reg == 4'h2)
          mode_next = ali_pkg::MODE_RUN;
      ali_pkg::MODE_RUN:
        if (idle_done)
          mode_next = ali_pkg::MODE_SAVE_REQ;
      ali_pkg::MODE_SAVE_REQ:
        if (i_flash_busy)
          mode_next = ali_pkg::MODE_CHASE;
      ali_pkg::MODE_CHASE:
        if (!i_flash_busy)
          mode_next = ali_pkg::MODE_RUN;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      mode_reg <= ali_pkg::MODE_POWERUP;
    else
      mode_reg <= mode_next;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      o_flash_start <= 1'b0;
    else
      o_flash_start <= (mode_next == ali_pkg::MODE_SAVE_REQ);
  end

  // Step timer for power-up and chase
  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst || mode_reg != mode_next)
    begin
      step_reg <= 32'h0;
      seq_reg  <= 4'h0;
    end
    else if (step_done)
    begin
      step_reg <= 32'h0;
      seq_reg  <= seq_reg + 4'h1;
    end
    else
      step_reg <= step_reg + 32'h1;
  end

  // ---------------------------------------------------------------------------
  // LED composition
  // ---------------------------------------------------------------------------
  always_comb
  begin
    led_next = '0;
    unique case (mode_reg)
      ali_pkg::MODE_POWERUP:
        if (seq_reg == 4'h0)
          led_next[ali_pkg::LED_PWR_IN] = 1'b1;
        else if (seq_reg == 4'h1)
          led_next[ali_pkg::LED_RX] = 1'b1;
        else
          led_next[ali_pkg::LED_TX] = 1'b1;
      ali_pkg::MODE_CHASE:
        led_next[seq_reg] = 1'b1;
      ali_pkg::MODE_RUN, ali_pkg::MODE_SAVE_REQ:
      begin
        led_next[ali_pkg::LED_PWR_IN]  = led_drive(1'b0, heart_on_reg, pwm_reg);
        led_next[ali_pkg::LED_PWR_OUT] = led_drive(1'b0, heart_on_reg, pwm_reg);
        led_next[ali_pkg::LED_RX]      = led_drive(act[0], 1'b0, pwm_reg);
        led_next[ali_pkg::LED_TX]      = led_drive(act[1], 1'b0, pwm_reg);
        led_next[ali_pkg::LED_USB_RX]  = led_drive(act[2], 1'b0, pwm_reg);
        led_next[ali_pkg::LED_USB_TX]  = led_drive(act[3], 1'b0, pwm_reg);
        led_next[ali_pkg::LED_MIDI_IN] = led_drive(act[4], ctrl_reg[ali_pkg::PHANTOM_BIT], pwm_reg);
        led_next[ali_pkg::LED_MIDI_OUT] = led_drive(act[5], 1'b0, pwm_reg);
        for (int j = 0; j < ali_pkg::N_JACK; j++)
        begin
          led_next[j] = i_jack_present[j]
                      && led_drive(act[ali_pkg::STR_JACK0 + j], 1'b1, pwm_reg);
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_sys_rst)
      led_reg <= '0;
    else
      led_reg <= led_next;
  end

  assign o_led_jack     = led_reg[ali_pkg::N_JACK-1:0];
  assign o_led_pwr_in   = led_reg[ali_pkg::LED_PWR_IN];
  assign o_led_rx       = led_reg[ali_pkg::LED_RX];
  assign o_led_tx       = led_reg[ali_pkg::LED_TX];
  assign o_led_pwr_out  = led_reg[ali_pkg::LED_PWR_OUT];
  assign o_led_usb_rx   = led_reg[ali_pkg::LED_USB_RX];
  assign o_led_usb_tx   = led_reg[ali_pkg::LED_USB_TX];
  assign o_led_midi_in  = led_reg[ali_pkg::LED_MIDI_IN];
  assign o_led_midi_out = led_reg[ali_pkg::LED_MIDI_OUT];

endmodule : ali_top

`default_nettype wire

//--- tb/ali_monitor.sv
// Port-level checker for the activity indicator block.
// Assumes scaled-down timing parameters from the bench.
`timescale 1ns/10ps
`default_nettype none

module ali_monitor #(
  parameter int unsigned P_STEP_CYC = 4,
  parameter int unsigned P_IDLE_CYC = 20
) (
  input wire logic        i_core_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_midi_in_evt,
  input wire logic        i_usb_in_evt,
  input wire logic        i_edit_evt,
  input wire logic [7:0]  i_pedal_evt,
  input wire logic [7:0]  i_jack_present,
  input wire logic        i_flash_busy,
  input wire logic        o_flash_start,
  input wire logic        o_fwd_midi_out,
  input wire logic        o_fwd_usb_out,
  input wire logic        o_thru_forward_switch,
  input wire logic        o_led_rx,
  input wire logic        o_led_usb_rx,
  input wire logic [7:0]  o_led_jack
);
  logic [7:0]  up_cnt;
  logic [2:0]  calm_cnt;
  logic [31:0] idle_cnt;
  logic        quiet;

  // Normal display: powerup over, chase settled
  assign quiet = (up_cnt > 8'(3 * P_STEP_CYC + 4)) && (calm_cnt > 3'd3);

  always_ff @(posedge i_core_clk)
    if (i_sys_rst) up_cnt <= 8'h00;
    else if (up_cnt != 8'hFF) up_cnt <= up_cnt + 8'h01;

  always_ff @(posedge i_core_clk)
    if (i_sys_rst || i_flash_busy) calm_cnt <= 3'h0;
    else if (calm_cnt != 3'h7) calm_cnt <= calm_cnt + 3'h1;

  // Edits: messages and control writes
  always_ff @(posedge i_core_clk)
    if (i_sys_rst || i_edit_evt || (i_psel && i_penable && i_pwrite && i_paddr == 12'h000)) idle_cnt <= 32'h0;
    else if (idle_cnt != 32'hFFFFFFFF) idle_cnt <= idle_cnt + 32'h1;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  ready_one_wait_a: assert property (i_psel && $rose(i_penable) |=> o_pready)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  bad_addr_err_a: assert property (o_pready |-> o_pslverr == (i_paddr != 12'h000 && i_paddr != 12'h004))
    else $error("error flag wrong for address");
  err_data_zero_a: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
    else $error("read data not zero on error");
  thru_fwd_a: assert property (i_midi_in_evt && o_thru_forward_switch |=> o_fwd_midi_out)
    else $error("midi in not forwarded to midi out");
  no_usb_echo_a: assert property (i_usb_in_evt && !i_midi_in_evt && !(|i_pedal_evt) |=> !o_fwd_usb_out)
    else $error("usb message echoed to usb");
  rx_led_hold_a: assert property (quiet && (i_midi_in_evt || i_usb_in_evt || i_edit_evt) |-> ##3 (o_led_rx || i_flash_busy) [*4])
    else $error("receive led not held bright");
  usb_rx_led_a: assert property (quiet && i_usb_in_evt |-> ##3 (o_led_usb_rx || i_flash_busy))
    else $error("usb receive led not lit");
  jack_flash_a: assert property (quiet && |(i_pedal_evt & i_jack_present)
    |-> ##3 (|(o_led_jack & $past(i_pedal_evt & i_jack_present, 3)) || i_flash_busy))
    else $error("jack led not flashed");
  jack_dark_a: assert property (quiet && !i_flash_busy
    |-> (o_led_jack & ~(i_jack_present | $past(i_jack_present) | $past(i_jack_present, 2))) == 8'h00)
    else $error("jack led lit without plug");
  flash_wait_a: assert property (o_flash_start && !i_flash_busy |=> o_flash_start)
    else $error("save request dropped early");
  save_gap_a: assert property ($rose(o_flash_start) |-> idle_cnt >= P_IDLE_CYC - 2)
    else $error("save started before idle gap");

  cover property (i_psel && i_penable && i_pwrite && o_pready);
  cover property ($rose(o_flash_start));
  cover property (o_pready && o_pslverr);
endmodule : ali_monitor

bind ali_top ali_monitor #(
  .P_STEP_CYC(P_STEP_CYC),
  .P_IDLE_CYC(P_IDLE_CYC)
) u_ali_monitor (
  .i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .i_midi_in_evt, .i_usb_in_evt, .i_edit_evt,
  .i_pedal_evt, .i_jack_present, .i_flash_busy, .o_flash_start, .o_fwd_midi_out,
  .o_fwd_usb_out, .o_thru_forward_switch, .o_led_rx, .o_led_usb_rx, .o_led_jack
);

`default_nettype wire

//--- tb/ali_flash_model.sv
// Behavioural flash controller on the far side of the save handshake.
// Assumes the block holds its start request until busy is seen.
`timescale 1ns/10ps
`default_nettype none

module ali_flash_model #(
  parameter int unsigned P_LEN = 30
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_start,
  output var  logic o_busy
);
  int unsigned cnt;
  logic        slow;

  // Prompt and slow answers in turn
  always_ff @(posedge i_core_clk)
    if (i_sys_rst)
    begin
      cnt    <= 0;
      slow   <= 1'b0;
      o_busy <= 1'b0;
    end
    else if (!o_busy)
    begin
      cnt <= (i_start && cnt < (slow ? 6 : 0)) ? cnt + 1 : 0;
      if (i_start && cnt >= (slow ? 6 : 0))
      begin
        o_busy <= 1'b1;
        slow   <= !slow;
      end
    end
    else if (cnt == P_LEN)
    begin
      o_busy <= 1'b0;
      cnt    <= 0;
    end
    else cnt <= cnt + 1;
endmodule : ali_flash_model

`default_nettype wire

//--- tb/test_activity_led_indicator.sv
// Self-checking bench for the indicator block with a flash partner.
// Assumes the bound checker and scaled timing parameters.
`timescale 1ns/10ps
`default_nettype none

module test_activity_led_indicator;
  localparam int unsigned PS = 4;
  localparam int unsigned PI = 20;
  logic        i_core_clk = 1'b0, i_sys_rst = 1'b1, i_flash_busy;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, seed = 32'h7A5A, rd, r;
  logic        o_pready, o_pslverr, o_flash_start, o_fwd_midi_out, o_fwd_usb_out;
  logic        i_midi_in_evt = 1'b0, i_usb_in_evt = 1'b0, i_edit_evt = 1'b0, er;
  logic [7:0]  i_pedal_evt = 8'h00, i_jack_present = 8'h0F, o_led_jack;
  logic        o_thru_forward_switch, o_midi_phantom_power, o_led_pwr_in, o_led_rx;
  logic        o_led_tx, o_led_usb_rx, o_led_midi_in, o_led_pwr_out, o_led_usb_tx, o_led_midi_out;
  logic [5:0]  sw;
  int          num_errors = 0, n_checks = 0, cyc = 0, chase_hits = 0, n;
  int          t_pw = -1, t_rx = -1, t_tx = -1;
  int          cnt [4];

  ali_top #(.P_PULSE_CYC(8), .P_STEP_CYC(PS), .P_HEART_CYC(16), .P_IDLE_CYC(PI)) i_dut (
    .i_core_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_midi_in_evt, .i_usb_in_evt, .i_edit_evt,
    .i_pedal_evt, .i_jack_present, .i_flash_busy, .o_flash_start, .o_fwd_midi_out,
    .o_fwd_usb_out, .o_thru_forward_switch, .o_midi_phantom_power, .o_led_pwr_in,
    .o_led_pwr_out, .o_led_rx, .o_led_tx, .o_led_usb_rx, .o_led_usb_tx,
    .o_led_midi_in, .o_led_midi_out, .o_led_jack
  );

  ali_flash_model u_flash (.i_core_clk, .i_sys_rst, .i_start(o_flash_start), .o_busy(i_flash_busy));

  always #5 i_core_clk = ~i_core_clk;

  always @(posedge i_core_clk)
  begin
    cyc <= cyc + 1;
    if (i_flash_busy && o_led_jack != 8'h00) chase_hits <= chase_hits + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [1:0] fwd_exp(input logic [5:0] s, input logic m, input logic u, input logic p);
    return {(p & s[3]) | (m & s[4]), (p & s[0]) | (m & s[1]) | (u & s[2])};
  endfunction : fwd_exp

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do @(posedge i_core_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic meas;
    cnt = '{default: 0};
    repeat (256)
    begin
      @(posedge i_core_clk);
      #1;
      cnt[0] += int'(o_led_jack[0]);
      cnt[1] += int'(o_led_jack[7]);
      cnt[2] += int'(o_led_pwr_in & o_led_pwr_out);
      cnt[3] += int'(o_led_midi_in);
    end
  endtask : meas

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (3) @(posedge i_core_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_core_clk);
    #1;
    chk(o_thru_forward_switch, 1);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge i_core_clk);
      #1;
      if (o_led_pwr_in === 1'b1 && t_pw < 0) t_pw = i;
      if (o_led_rx === 1'b1 && t_rx < 0) t_rx = i;
      if (o_led_tx === 1'b1 && t_tx < 0) t_tx = i;
    end
    chk(t_pw >= 0 && t_pw < t_rx, 1);
    chk(t_tx - t_rx, PS);
    meas();
    chk(cnt[0], 16);
    chk(cnt[1], 0);
    chk(cnt[2] > 0 && cnt[2] <= 16, 1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[7:0], 8'h0F);
    apb(1'b0, 12'h008, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    // Random routing switches, plugs and strobes
    repeat (6)
    begin
      sw = 6'(xs()) & 6'h1F;
      apb(1'b1, 12'h000, {26'h0, sw});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {26'h0, sw});
      chk(o_thru_forward_switch, sw[1]);
      i_jack_present <= 8'(xs());
      repeat (12)
      begin
        r = xs();
        @(posedge i_core_clk);
        i_midi_in_evt <= r[0];
        i_usb_in_evt <= r[1];
        i_edit_evt <= r[2] & r[3];
        i_pedal_evt <= r[15:8] & i_jack_present;
        @(posedge i_core_clk);
        {i_midi_in_evt, i_usb_in_evt, i_edit_evt, i_pedal_evt} <= 11'h000;
        #1;
        chk(fwd_exp(sw, r[0], r[1], |(r[15:8] & i_jack_present)), {o_fwd_usb_out, o_fwd_midi_out});
      end
    end
    repeat (100) @(posedge i_core_clk);
    i_jack_present <= 8'h00;
    // Edit restarts the idle gap, then save
    apb(1'b1, 12'h000, 32'h3F);
    repeat (15) @(posedge i_core_clk);
    i_edit_evt <= 1'b1;
    @(posedge i_core_clk);
    i_edit_evt <= 1'b0;
    for (n = 0; n < 60 && o_flash_start !== 1'b1; n++) @(posedge i_core_clk);
    chk(n >= PI && n <= PI + 3, 1);
    for (n = 0; n < 40 && i_flash_busy !== 1'b1; n++) @(posedge i_core_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[11:8], 4'hB);
    for (n = 0; n < 80 && i_flash_busy !== 1'b0; n++) @(posedge i_core_clk);
    repeat (4) @(posedge i_core_clk);
    chk(chase_hits > 0, 1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[9:8], 2'h1);
    meas();
    chk(cnt[3], 16);
    @(posedge i_core_clk);
    i_midi_in_evt <= 1'b1;
    @(posedge i_core_clk);
    i_midi_in_evt <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    #1;
    chk({o_led_midi_in, o_led_midi_out, o_led_usb_tx, o_midi_phantom_power}, 4'hF);
    test_done();
  end
endmodule : test_activity_led_indicator

`default_nettype wire
